// >>> rtl/psh_status_bits.sv
// Function
// - received completer abort sets rx abort flag; w1c, resets to 0.
// - sent completer abort sets tx abort flag; w1c, resets to 0.
// - select timing, fast back-to-back and 66 MHz capable bits read zero.
// - parity flag sets only when enabled, on poisoned completion or write.
// - with parity response disabled the parity flag never sets; w1c, reset 0.
// - the capabilities-list bit is read-only and reads one.
// - the interrupt-status bit is read-only and reads zero.
// - reserved bit 22 and bits 18 to 11 are read-only and read zero.
// - parity response enable at bit 6 is read-write, reset 0, gates parity.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module psh_status_bits #(
    parameter int ADDR_W = 12
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_RX_CPL_ABORT,
    input wire logic I_TX_CPL_ABORT,
    input wire logic I_RX_POISONED_CPL,
    input wire logic I_TX_POISONED_WR,
    output logic [31:0] O_RDATA,
    output logic O_PARITY_RESPONSE_ENABLE,
    output logic O_IRQ
);
    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (ADDR_W < 7 || ADDR_W > 12) begin : g_chk
        $error("ADDR_W must lie in 7..12");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [11:0] off
    );
        return addr == off[ADDR_W-1:0];
    endfunction

    // set wins over clear
    function automatic logic w1c(
        input logic cur,
        input logic set,
        input logic clr
    );
        return (cur & ~clr) | set;
    endfunction

    psh_pkg::psh_event_type evt;
    psh_pkg::psh_state_type st;
    psh_pkg::psh_state_type next_st;
    logic wr_csr;
    logic rd_csr;
    logic mdp_set;
    logic [2:0] irq_set;
    logic [31:0] csr_view;

    assign evt = '{
        rx_cpl_abort: I_RX_CPL_ABORT,
        tx_cpl_abort: I_TX_CPL_ABORT,
        rx_poisoned_cpl: I_RX_POISONED_CPL,
        tx_poisoned_wr: I_TX_POISONED_WR
    };

    assign wr_csr = I_WR && hit(I_ADDR, psh_pkg::OFF_CMD_STATUS);
    assign rd_csr = I_RD && hit(I_ADDR, psh_pkg::OFF_CMD_STATUS);

    // ----------------------------------------------------------------
    // register image
    // ----------------------------------------------------------------
    always_comb begin
        csr_view = 32'h0;
        csr_view[psh_pkg::BIT_RX_CA] = st.rx_completer_abort_flag;
        csr_view[psh_pkg::BIT_TX_CA] = st.tx_completer_abort_flag;
        csr_view[psh_pkg::BIT_SEL_HI:psh_pkg::BIT_SEL_LO] =
            psh_pkg::VAL_SEL;
        csr_view[psh_pkg::BIT_MDP] = st.master_data_parity_flag;
        csr_view[psh_pkg::BIT_FB2B] = psh_pkg::VAL_FB2B;
        csr_view[psh_pkg::BIT_RSV22] = psh_pkg::VAL_RSV;
        csr_view[psh_pkg::BIT_SPD66] = psh_pkg::VAL_SPD66;
        csr_view[psh_pkg::BIT_CAPL] = psh_pkg::VAL_CAPL;
        csr_view[psh_pkg::BIT_INTST] = psh_pkg::VAL_INTST;
        csr_view[psh_pkg::BIT_RSV_HI:psh_pkg::BIT_RSV_LO] =
            {8{psh_pkg::VAL_RSV}};
        csr_view[psh_pkg::BIT_PRE] = st.parity_response_enable;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // gated by the enable as it stands this cycle
        mdp_set = st.parity_response_enable
            && (evt.rx_poisoned_cpl || evt.tx_poisoned_wr);
        next_st.rx_completer_abort_flag = w1c(
            st.rx_completer_abort_flag,
            evt.rx_cpl_abort,
            wr_csr && I_WDATA[psh_pkg::BIT_RX_CA]);
        next_st.tx_completer_abort_flag = w1c(
            st.tx_completer_abort_flag,
            evt.tx_cpl_abort,
            wr_csr && I_WDATA[psh_pkg::BIT_TX_CA]);
        next_st.master_data_parity_flag = w1c(
            st.master_data_parity_flag,
            mdp_set,
            wr_csr && I_WDATA[psh_pkg::BIT_MDP]);
        if (wr_csr) begin
            next_st.parity_response_enable =
                I_WDATA[psh_pkg::BIT_PRE];
        end
        // interrupt status follows the same events
        irq_set = 3'h0;
        irq_set[psh_pkg::IRQ_RX_CA] = evt.rx_cpl_abort;
        irq_set[psh_pkg::IRQ_TX_CA] = evt.tx_cpl_abort;
        irq_set[psh_pkg::IRQ_MDP] = mdp_set;
        for (int i = 0; i < 3; i++) begin
            next_st.irq_status[i] = w1c(
                st.irq_status[i],
                irq_set[i],
                I_WR && hit(I_ADDR, psh_pkg::OFF_IRQ_CLEAR)
                    && I_WDATA[i]);
        end
        if (I_WR && hit(I_ADDR, psh_pkg::OFF_IRQ_ENABLE)) begin
            next_st.irq_enable = I_WDATA[2:0];
        end
        // read data stands one cycle, zero otherwise
        next_st.rdata = 32'h0;
        if (I_RD) begin
            if (rd_csr) begin
                next_st.rdata = csr_view;
            end else if (hit(I_ADDR, psh_pkg::OFF_IRQ_STATUS)) begin
                next_st.rdata = {29'h0, st.irq_status};
            end else if (hit(I_ADDR, psh_pkg::OFF_IRQ_ENABLE)) begin
                next_st.rdata = {29'h0, st.irq_enable};
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st.rx_completer_abort_flag <= psh_pkg::RST_FLAG;
            st.tx_completer_abort_flag <= psh_pkg::RST_FLAG;
            st.master_data_parity_flag <= psh_pkg::RST_FLAG;
            st.parity_response_enable <= psh_pkg::RST_PRE;
            st.irq_status <= psh_pkg::RST_IRQ;
            st.irq_enable <= psh_pkg::RST_IRQ;
            st.rdata <= 32'h0;
        end else begin
            st <= next_st;
        end
    end

    assign O_RDATA = st.rdata;
    assign O_PARITY_RESPONSE_ENABLE = st.parity_response_enable;
    assign O_IRQ = |(st.irq_status & st.irq_enable);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_rx_set;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_RX_CPL_ABORT |=> st.rx_completer_abort_flag;
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("rx abort flag not set");

    property p_tx_set;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_TX_CPL_ABORT ##1 !I_WR [*2]
            |-> st.tx_completer_abort_flag;
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("tx abort flag not held");

    property p_fixed_zero;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        rd_csr |=> O_RDATA[psh_pkg::BIT_SEL_HI:psh_pkg::BIT_SEL_LO] == 2'h0
            && !O_RDATA[psh_pkg::BIT_FB2B]
            && !O_RDATA[psh_pkg::BIT_SPD66];
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("select timing or capable bits not zero");

    property p_mdp_set;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        O_PARITY_RESPONSE_ENABLE
            && (I_RX_POISONED_CPL || I_TX_POISONED_WR)
            |=> st.master_data_parity_flag && st.irq_status[2];
    endproperty
    a_mdp_set: assert property (p_mdp_set)
        else $error("parity flag not set on poisoned traffic");

    property p_mdp_block;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !O_PARITY_RESPONSE_ENABLE && !st.master_data_parity_flag
            |=> !st.master_data_parity_flag;
    endproperty
    a_mdp_block: assert property (p_mdp_block)
        else $error("parity flag set while disabled");

    property p_cap;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        rd_csr |=> O_RDATA[psh_pkg::BIT_CAPL];
    endproperty
    a_cap: assert property (p_cap)
        else $error("capabilities bit not one");

    property p_intst;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        rd_csr |=> !O_RDATA[psh_pkg::BIT_INTST];
    endproperty
    a_intst: assert property (p_intst)
        else $error("interrupt status bit not zero");

    property p_rsv;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        rd_csr |=> !O_RDATA[psh_pkg::BIT_RSV22]
            && O_RDATA[psh_pkg::BIT_RSV_HI:psh_pkg::BIT_RSV_LO] == 8'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits not zero");

    property p_pre;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr |=> O_PARITY_RESPONSE_ENABLE
            == $past(I_WDATA[psh_pkg::BIT_PRE]);
    endproperty
    a_pre: assert property (p_pre)
        else $error("parity response enable not written");

    property p_w0;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && !I_WDATA[psh_pkg::BIT_RX_CA]
            && st.rx_completer_abort_flag
            |=> st.rx_completer_abort_flag;
    endproperty
    a_w0: assert property (p_w0)
        else $error("write of zero cleared a flag");

    property p_irq;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_RX_CPL_ABORT && st.irq_enable[0] && !I_WR |=> O_IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    // ----------------------------------------------------------------
    // clear, hold and read-back checks
    // ----------------------------------------------------------------
    property p_rx_clr;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && I_WDATA[psh_pkg::BIT_RX_CA] && !I_RX_CPL_ABORT
            |=> !st.rx_completer_abort_flag;
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("rx abort flag not cleared");

    property p_tx_clr;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && I_WDATA[psh_pkg::BIT_TX_CA] && !I_TX_CPL_ABORT
            |=> !st.tx_completer_abort_flag;
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("tx abort flag not cleared");

    property p_tx_w0;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && !I_WDATA[psh_pkg::BIT_TX_CA]
            && st.tx_completer_abort_flag
            |=> st.tx_completer_abort_flag;
    endproperty
    a_tx_w0: assert property (p_tx_w0)
        else $error("write of zero cleared tx abort flag");

    property p_mdp_clr;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && I_WDATA[psh_pkg::BIT_MDP]
            && !I_RX_POISONED_CPL && !I_TX_POISONED_WR
            |=> !st.master_data_parity_flag;
    endproperty
    a_mdp_clr: assert property (p_mdp_clr)
        else $error("parity flag not cleared");

    property p_mdp_w0;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        wr_csr && !I_WDATA[psh_pkg::BIT_MDP]
            && st.master_data_parity_flag
            |=> st.master_data_parity_flag;
    endproperty
    a_mdp_w0: assert property (p_mdp_w0)
        else $error("write of zero cleared parity flag");

    property p_mdp_only;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !st.master_data_parity_flag
            && !I_RX_POISONED_CPL && !I_TX_POISONED_WR
            |=> !st.master_data_parity_flag;
    endproperty
    a_mdp_only: assert property (p_mdp_only)
        else $error("parity flag set without poisoned traffic");

    property p_pre_hold;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !wr_csr |=> $stable(O_PARITY_RESPONSE_ENABLE);
    endproperty
    a_pre_hold: assert property (p_pre_hold)
        else $error("parity response enable changed unwritten");

    property p_rd_idle;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !I_RD |=> O_RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");

    property p_rd_flags;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        rd_csr |=> O_RDATA[psh_pkg::BIT_RX_CA]
            == $past(st.rx_completer_abort_flag)
            && O_RDATA[psh_pkg::BIT_TX_CA] == $past(st.tx_completer_abort_flag);
    endproperty
    a_rd_flags: assert property (p_rd_flags)
        else $error("abort flags read back wrong");

    property p_irq_clr;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_WR && hit(I_ADDR, psh_pkg::OFF_IRQ_CLEAR)
            && I_WDATA[psh_pkg::IRQ_RX_CA] && !I_RX_CPL_ABORT
            |=> !st.irq_status[psh_pkg::IRQ_RX_CA];
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("interrupt status not cleared");

    property p_irq_en;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_WR && hit(I_ADDR, psh_pkg::OFF_IRQ_ENABLE)
            |=> st.irq_enable == $past(I_WDATA[2:0]);
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("interrupt enable not written");
endmodule // psh_status_bits
`default_nettype wire

// >>> shared/psh_pkg.sv
`default_nettype none
package psh_pkg;
    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CMD_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h040;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h044;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h048;

    // ----------------------------------------------------------------
    // command/status field positions
    // ----------------------------------------------------------------
    localparam int BIT_RX_CA = 28;
    localparam int BIT_TX_CA = 27;
    localparam int BIT_SEL_LO = 25;
    localparam int BIT_SEL_HI = 26;
    localparam int BIT_MDP = 24;
    localparam int BIT_FB2B = 23;
    localparam int BIT_RSV22 = 22;
    localparam int BIT_SPD66 = 21;
    localparam int BIT_CAPL = 20;
    localparam int BIT_INTST = 19;
    localparam int BIT_RSV_HI = 18;
    localparam int BIT_RSV_LO = 11;
    localparam int BIT_PRE = 6;

    // ----------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------
    localparam logic RST_FLAG = 1'h0;
    localparam logic RST_PRE = 1'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [1:0] VAL_SEL = 2'h0;
    localparam logic VAL_FB2B = 1'h0;
    localparam logic VAL_SPD66 = 1'h0;
    localparam logic VAL_CAPL = 1'h1;
    localparam logic VAL_INTST = 1'h0;
    localparam logic VAL_RSV = 1'h0;

    // ----------------------------------------------------------------
    // interrupt bit positions
    // ----------------------------------------------------------------
    localparam int IRQ_RX_CA = 0;
    localparam int IRQ_TX_CA = 1;
    localparam int IRQ_MDP = 2;

    typedef struct packed {
        logic rx_cpl_abort;
        logic tx_cpl_abort;
        logic rx_poisoned_cpl;
        logic tx_poisoned_wr;
    } psh_event_type;

    typedef struct packed {
        logic rx_completer_abort_flag;
        logic tx_completer_abort_flag;
        logic master_data_parity_flag;
        logic parity_response_enable;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic [31:0] rdata;
    } psh_state_type;
endpackage
`default_nettype wire

// >>> verif/psh_pcie_model.sv
`timescale 1ns/1ns
`default_nettype none
module psh_pcie_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire psh_pkg::psh_event_type i_req,
    input wire logic [1:0] i_delay,
    output var psh_pkg::psh_event_type o_ev
);
    // ----------------------------------------------------------------
    // link side: one event pulse after a chosen delay
    // ----------------------------------------------------------------
    psh_pkg::psh_event_type held;
    logic [1:0] cnt;
    logic busy;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ev <= '0;
            held <= '0;
            cnt <= 2'h0;
            busy <= 1'h0;
        end else begin
            o_ev <= '0;
            if (i_req != '0) begin
                held <= i_req;
                cnt <= i_delay;
                busy <= 1'h1;
            end else if (busy) begin
                if (cnt == 2'h0) begin
                    o_ev <= held;
                    busy <= 1'h0;
                end else begin
                    cnt <= cnt - 2'h1;
                end
            end
        end
    end
endmodule // psh_pcie_model
`default_nettype wire

// >>> verif/psh_status_bits_test.sv
`timescale 1ns/1ns
`default_nettype none
module psh_status_bits_test;
    localparam logic [31:0] BASE = 32'h1 << psh_pkg::BIT_CAPL;
    localparam logic [31:0] PRE = 32'h1 << psh_pkg::BIT_PRE;
    localparam logic [31:0] RXA = 32'h1 << psh_pkg::BIT_RX_CA;
    localparam logic [31:0] TXA = 32'h1 << psh_pkg::BIT_TX_CA;
    localparam logic [31:0] MDP = 32'h1 << psh_pkg::BIT_MDP;
    localparam logic [11:0] CS = psh_pkg::OFF_CMD_STATUS;
    logic clk, rst_n, wr_s, rd_s, o_pre, o_irq;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] dly;
    psh_pkg::psh_event_type req, ev_w;
    int err_total, comparisons, cycles;
    psh_pcie_model link (.i_clk(clk), .i_reset_n(rst_n), .i_req(req),
        .i_delay(dly), .o_ev(ev_w));
    psh_status_bits uut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
        .I_RX_CPL_ABORT(ev_w.rx_cpl_abort),
        .I_TX_CPL_ABORT(ev_w.tx_cpl_abort),
        .I_RX_POISONED_CPL(ev_w.rx_poisoned_cpl),
        .I_TX_POISONED_WR(ev_w.tx_poisoned_wr), .O_RDATA(rdata),
        .O_PARITY_RESPONSE_ENABLE(o_pre), .O_IRQ(o_irq));
    always #25 clk = ~clk;
    // ----------------------------------------------------------------
    // bus tasks and checks
    // ----------------------------------------------------------------
    task automatic results;
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_s <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'h0;
        #1 chk(rdata, exp);
    endtask
    task automatic ev(input logic [3:0] v, input logic [1:0] d);
        @(posedge clk);
        req <= psh_pkg::psh_event_type'(v);
        dly <= d;
        @(posedge clk);
        req <= '0;
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            results;
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        addr = 12'h0;
        wdata = 32'h0;
        wr_s = 1'h0;
        rd_s = 1'h0;
        req = '0;
        dly = 2'h0;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd(CS, BASE);
        chk({31'h0, o_pre}, 32'h0);
        rd(psh_pkg::OFF_IRQ_STATUS, 32'h0);
        wr(CS, 32'hffff_ffff);
        rd(CS, BASE | PRE);
        chk({31'h0, o_pre}, 32'h1);
        ev(4'b1000, 2'h0);
        rd(CS, BASE | PRE | RXA);
        ev(4'b0100, 2'h3);
        rd(CS, BASE | PRE | RXA | TXA);
        ev(4'b0010, 2'h1);
        rd(CS, BASE | PRE | RXA | TXA | MDP);
        wr(CS, PRE);
        rd(CS, BASE | PRE | RXA | TXA | MDP);
        wr(CS, PRE | RXA);
        rd(CS, BASE | PRE | TXA | MDP);
        wr(CS, PRE | TXA | MDP);
        rd(CS, BASE | PRE);
        wr(CS, 32'h0);
        chk({31'h0, o_pre}, 32'h0);
        ev(4'b0011, 2'h0);
        rd(CS, BASE);
        wr(CS, PRE);
        ev(4'b0001, 2'h2);
        rd(CS, BASE | PRE | MDP);
        // interrupt status, enable, mask and clear
        rd(psh_pkg::OFF_IRQ_STATUS, 32'h7);
        chk({31'h0, o_irq}, 32'h0);
        wr(psh_pkg::OFF_IRQ_ENABLE, 32'h4);
        chk({31'h0, o_irq}, 32'h1);
        rd(psh_pkg::OFF_IRQ_ENABLE, 32'h4);
        wr(psh_pkg::OFF_IRQ_CLEAR, 32'h7);
        chk({31'h0, o_irq}, 32'h0);
        rd(psh_pkg::OFF_IRQ_STATUS, 32'h0);
        ev(4'b1000, 2'h0);
        chk({31'h0, o_irq}, 32'h0);
        wr(psh_pkg::OFF_IRQ_ENABLE, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        // enabled event after a clear raises the line again
        wr(psh_pkg::OFF_IRQ_CLEAR, 32'h1);
        chk({31'h0, o_irq}, 32'h0);
        ev(4'b1000, 2'h1);
        chk({31'h0, o_irq}, 32'h1);
        rd(CS, BASE | PRE | MDP | RXA);
        rd(psh_pkg::OFF_IRQ_CLEAR, 32'h0);
        rd(12'h100, 32'h0);
        @(posedge clk);
        #1 chk(rdata, 32'h0);
        results;
    end
endmodule // psh_status_bits_test
`default_nettype wire
